// ---- hdl/crs_cfg.svh ----
// Purpose: Constants for the cold reset and boot vector sequencer.
// Assumes: One 40 MHz clock shared by both ends.
// Notes: Timing counts are derived from the figures below.
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define CRS_CLK_MHZ 40
`define CRS_CLK_PERIOD_NS 25

// ----------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------
`define CRS_DATA_W 32
`define CRS_VEC_W 16

// ----------------------------------------------------------------------
// Boot vector fields
// ----------------------------------------------------------------------
`define CRS_VEC_FAST_RESET 9
`define CRS_VEC_HOLD_CLOCK 11
`define CRS_VEC_RSVD_HI 15
`define CRS_VEC_RSVD_LO 14
`define CRS_VEC_RESET 16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CRS_RESET_NORMAL_CYCLES 13'h1000
`define CRS_RESET_FAST_CYCLES 13'h0040
`define CRS_RESET_CNT_W 13
`define CRS_COLD_HOLD_MS 110
`define CRS_COLD_HOLD_CYCLES (`CRS_COLD_HOLD_MS * `CRS_CLK_MHZ * 1000)
`define CRS_COLD_CNT_W 32
`define CRS_DMA_EXTRA_NS 7
`define CRS_DMA_PULSE_CYCLES \
    ((2 * `CRS_CLK_PERIOD_NS + `CRS_DMA_EXTRA_NS - 1) / `CRS_CLK_PERIOD_NS)
`define CRS_DMA_CNT_W 2

`endif

// ---- hdl/crs_pkg.sv ----
// Purpose: Types for the cold reset and boot vector sequencer.
// Assumes: Constants come from crs_cfg.svh.
// Notes: Nothing here is imported; use crs_pkg::name.
package crs_pkg;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DEV_COLD,
        DEV_HANDOVER,
        DEV_RESET_HOLD,
        DEV_RUN,
        DEV_WARM
    } crs_dev_state_e;

    typedef enum logic [1:0] {
        CTL_IDLE,
        CTL_COLD,
        CTL_RELEASE
    } crs_ctl_state_e;

endpackage

// ---- hdl/crs_link_if.sv ----
// Purpose: Board-level wires between the device and the reset controller.
// Assumes: Both ends run on the same clock.
// Notes: Two-way lines are resolved here from the output enables.
`include "crs_cfg.svh"

interface crs_link_if;

    // ------------------------------------------------------------------
    // Wires
    // ------------------------------------------------------------------
    logic cold_reset_in_n;
    logic system_reset_n;
    logic dev_system_reset_n_out;
    logic dev_system_reset_oe;
    logic ctl_system_reset_n_out;
    logic ctl_system_reset_oe;
    logic [`CRS_DATA_W-1:0] memory_data_bus;
    logic [`CRS_DATA_W-1:0] dev_data_out;
    logic dev_data_oe;
    logic [`CRS_VEC_W-1:0] ctl_data_out;
    logic ctl_data_oe;
    logic xcvr_output_enable_n;
    logic xcvr_direction_n;
    logic system_clock_out;
    logic dma_request_in_n;
    logic dma_done_in_n;

    // ------------------------------------------------------------------
    // Resolution
    // ------------------------------------------------------------------
    // The reset line is pulled high; any enabled driver that outputs low pulls it low.
    assign system_reset_n = !((dev_system_reset_oe && !dev_system_reset_n_out) ||
                              (ctl_system_reset_oe && !ctl_system_reset_n_out));
    // The data bus reads zero when nobody drives it.
    assign memory_data_bus = dev_data_oe ? dev_data_out :
                             ctl_data_oe ? {{(`CRS_DATA_W-`CRS_VEC_W){1'b0}}, ctl_data_out} :
                             {`CRS_DATA_W{1'b0}};

    modport device (
        input cold_reset_in_n,
        input system_reset_n,
        output dev_system_reset_n_out,
        output dev_system_reset_oe,
        input memory_data_bus,
        output dev_data_out,
        output dev_data_oe,
        output xcvr_output_enable_n,
        output xcvr_direction_n,
        output system_clock_out,
        input dma_request_in_n,
        input dma_done_in_n
    );

    modport controller (
        output cold_reset_in_n,
        input system_reset_n,
        output ctl_system_reset_n_out,
        output ctl_system_reset_oe,
        input memory_data_bus,
        output ctl_data_out,
        output ctl_data_oe,
        input xcvr_output_enable_n,
        input xcvr_direction_n,
        input system_clock_out,
        output dma_request_in_n,
        output dma_done_in_n
    );

endinterface

// ---- hdl/crs_controller.sv ----
// Purpose: External reset controller that drives cold reset and the boot vector.
// Assumes: CLOCK at 40 MHz; user inputs synchronous to CLOCK.
// Notes: A cold reset starts by itself after NRST is released.
`include "crs_cfg.svh"

module crs_controller #(
    parameter int unsigned COLD_HOLD_CYCLES = `CRS_COLD_HOLD_CYCLES
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic START,
    input wire logic [`CRS_VEC_W-1:0] BOOT_VECTOR_IN,
    input wire logic WARM_RESET,
    input wire logic DMA_REQUEST,
    input wire logic DMA_DONE,
    output logic BUSY,
    output logic SYSTEM_RESET_LEVEL,
    crs_link_if.controller LINK
);

    // ------------------------------------------------------------------
    // Cold reset sequence
    // ------------------------------------------------------------------
    crs_pkg::crs_ctl_state_e state;
    crs_pkg::crs_ctl_state_e next_state;
    logic [`CRS_COLD_CNT_W-1:0] count;
    logic [`CRS_VEC_W-1:0] vector;
    logic [`CRS_VEC_W-1:0] clean_vector;
    wire count_done = (count <= `CRS_COLD_CNT_W'(1));

    // Reserved bits go out low.
    assign clean_vector = BOOT_VECTOR_IN &
        ~(16'hFFFF << `CRS_VEC_RSVD_LO);

    always_comb begin
        next_state = state;
        unique case (state)
            crs_pkg::CTL_IDLE: if (START) next_state = crs_pkg::CTL_COLD;
            crs_pkg::CTL_COLD: if (count_done) next_state = crs_pkg::CTL_RELEASE;
            crs_pkg::CTL_RELEASE: next_state = crs_pkg::CTL_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state <= crs_pkg::CTL_COLD;
            count <= `CRS_COLD_CNT_W'(COLD_HOLD_CYCLES);
            vector <= `CRS_VEC_RESET;
        end else begin
            state <= next_state;
            if (state == crs_pkg::CTL_IDLE) begin
                count <= `CRS_COLD_CNT_W'(COLD_HOLD_CYCLES);
                vector <= clean_vector;
            end else if (!count_done) begin
                count <= count - `CRS_COLD_CNT_W'(1);
            end
        end
    end

    // Cold reset rises first; the vector floats one cycle later.
    assign LINK.cold_reset_in_n = !(state == crs_pkg::CTL_COLD);
    assign LINK.ctl_data_oe = (state != crs_pkg::CTL_IDLE);
    assign LINK.ctl_data_out = vector;
    assign LINK.ctl_system_reset_n_out = 1'b0;
    assign LINK.ctl_system_reset_oe = WARM_RESET && (state == crs_pkg::CTL_IDLE);
    assign BUSY = (state != crs_pkg::CTL_IDLE);

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            SYSTEM_RESET_LEVEL <= 1'b0;
        end else begin
            SYSTEM_RESET_LEVEL <= LINK.system_reset_n;
        end
    end

    // ------------------------------------------------------------------
    // DMA pulses
    // ------------------------------------------------------------------
    logic [1:0] dma_trigger;
    logic [1:0] dma_active;
    assign dma_trigger = {DMA_DONE, DMA_REQUEST};

    for (genvar i = 0; i < 2; i++) begin : g_dma
        logic [`CRS_DMA_CNT_W-1:0] left;
        always_ff @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
                left <= `CRS_DMA_CNT_W'(0);
            end else if (dma_trigger[i] && left == `CRS_DMA_CNT_W'(0)) begin
                left <= `CRS_DMA_CNT_W'(`CRS_DMA_PULSE_CYCLES);
            end else if (left != `CRS_DMA_CNT_W'(0)) begin
                left <= left - `CRS_DMA_CNT_W'(1);
            end
        end
        assign dma_active[i] = (left != `CRS_DMA_CNT_W'(0));
    end

    assign LINK.dma_request_in_n = !dma_active[0];
    assign LINK.dma_done_in_n = !dma_active[1];

endmodule

// ---- hdl/crs_device.sv ----
// Purpose: Device end of the cold reset and boot vector sequence.
// Assumes: CLOCK at 40 MHz; cold reset and data pins synchronous to CLOCK.
// Notes: The system reset line is a two-way pin resolved in the interface.
//
// What this block does
// - Controller holds cold reset low 110 ms.
// - Cold reset low: assert reset, float bus.
// - Vector driven and sampled while cold low.
// - Vector floated only after cold release.
// - Cold release freezes last sampled vector.
// - Then drive bus, transceiver lines high.
// - Clock may stop from bus drive onward.
// - Negate system reset after bus handover.
// - After release, watch line as warm reset.
// - Reset line two-way, synchronised as input.
// - DMA input pulses last clock plus 7ns.
// - Reset 4096 cycles, or 64 when fast.
// - Hold-clock bit set keeps clock static.
// - Reserved vector bits 15:14 driven low.
`include "crs_cfg.svh"

module crs_device (
    input wire logic CLOCK,
    input wire logic NRST,
    output logic [`CRS_VEC_W-1:0] BOOT_VECTOR,
    output logic CORE_RESET_N,
    output logic WARM_RESET_ACTIVE,
    output logic DMA_REQUEST_ACTIVE,
    output logic DMA_DONE_ACTIVE,
    crs_link_if.device LINK
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    crs_pkg::crs_dev_state_e state;
    crs_pkg::crs_dev_state_e next_state;
    logic [`CRS_RESET_CNT_W-1:0] count;
    logic [`CRS_RESET_CNT_W-1:0] next_count;
    logic [`CRS_VEC_W-1:0] vector;
    logic warm_meta;
    logic warm_sync;

    wire cold_low = !LINK.cold_reset_in_n;
    wire fast_reset = vector[`CRS_VEC_FAST_RESET];
    wire hold_clock = vector[`CRS_VEC_HOLD_CLOCK];
    wire count_last = (count == `CRS_RESET_CNT_W'(1));
    wire [`CRS_RESET_CNT_W-1:0] reset_length =
        fast_reset ? `CRS_RESET_FAST_CYCLES : `CRS_RESET_NORMAL_CYCLES;

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_count = count;
        if (cold_low) begin
            next_state = crs_pkg::DEV_COLD;
        end else begin
            unique case (state)
                crs_pkg::DEV_COLD: begin
                    next_state = crs_pkg::DEV_HANDOVER;
                end
                crs_pkg::DEV_HANDOVER: begin
                    next_state = crs_pkg::DEV_RESET_HOLD;
                    next_count = reset_length;
                end
                crs_pkg::DEV_RESET_HOLD: begin
                    if (count_last) begin
                        next_state = crs_pkg::DEV_RUN;
                    end else begin
                        next_count = count - `CRS_RESET_CNT_W'(1);
                    end
                end
                crs_pkg::DEV_RUN: begin
                    if (!warm_sync) next_state = crs_pkg::DEV_WARM;
                end
                crs_pkg::DEV_WARM: begin
                    if (warm_sync) next_state = crs_pkg::DEV_RUN;
                end
                default: next_state = crs_pkg::DEV_COLD;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state <= crs_pkg::DEV_COLD;
            count <= `CRS_RESET_CNT_W'(0);
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // ------------------------------------------------------------------
    // Boot vector capture
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            vector <= `CRS_VEC_RESET;
        end else if (cold_low) begin
            vector <= LINK.memory_data_bus[`CRS_VEC_W-1:0];
        end
    end

    assign BOOT_VECTOR = vector;

    // ------------------------------------------------------------------
    // Pin drive, decoded from the next state
    // ------------------------------------------------------------------
    wire next_in_cold = (next_state == crs_pkg::DEV_COLD);
    wire next_drives_reset = next_in_cold ||
                             (next_state == crs_pkg::DEV_HANDOVER) ||
                             (next_state == crs_pkg::DEV_RESET_HOLD);
    wire next_core_reset = next_drives_reset || (next_state == crs_pkg::DEV_WARM);
    wire next_clock_held = hold_clock && !next_in_cold;

    logic drive_reset;
    logic drive_bus;
    logic xcvr_oe_n;
    logic xcvr_dir_n;
    logic sysclk;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            drive_reset <= 1'b1;
            drive_bus <= 1'b0;
            xcvr_oe_n <= 1'b0;
            xcvr_dir_n <= 1'b0;
            CORE_RESET_N <= 1'b0;
        end else begin
            drive_reset <= next_drives_reset;
            drive_bus <= !next_in_cold;
            xcvr_oe_n <= !next_in_cold;
            xcvr_dir_n <= !next_in_cold;
            CORE_RESET_N <= !next_core_reset;
        end
    end

    assign LINK.dev_system_reset_n_out = 1'b0;
    assign LINK.dev_system_reset_oe = drive_reset;
    assign LINK.dev_data_out = {`CRS_DATA_W{1'b0}};
    assign LINK.dev_data_oe = drive_bus;
    assign LINK.xcvr_output_enable_n = xcvr_oe_n;
    assign LINK.xcvr_direction_n = xcvr_dir_n;

    // ------------------------------------------------------------------
    // System clock output
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            sysclk <= 1'b0;
        end else if (!next_clock_held) begin
            sysclk <= !sysclk;
        end
    end

    // With the hold-clock bit set, held at its last level once the bus is driven.
    assign LINK.system_clock_out = sysclk;

    // ------------------------------------------------------------------
    // Warm reset input
    // ------------------------------------------------------------------
    // While the device drives the line it reads its own drive, so the
    // synchroniser is loaded high to avoid a false warm reset on release.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            warm_meta <= 1'b1;
            warm_sync <= 1'b1;
        end else begin
            warm_meta <= drive_reset ? 1'b1 : LINK.system_reset_n;
            warm_sync <= warm_meta;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            WARM_RESET_ACTIVE <= 1'b0;
        end else begin
            WARM_RESET_ACTIVE <= (next_state == crs_pkg::DEV_WARM);
        end
    end

    // ------------------------------------------------------------------
    // DMA inputs
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            DMA_REQUEST_ACTIVE <= 1'b0;
            DMA_DONE_ACTIVE <= 1'b0;
        end else begin
            DMA_REQUEST_ACTIVE <= !LINK.dma_request_in_n;
            DMA_DONE_ACTIVE <= !LINK.dma_done_in_n;
        end
    end

endmodule

// ---- dv/crs_link_sva.sv ----
// Purpose: Assertions on the link between device and reset controller.
// Assumes: One clock; NRST asynchronous and active low.
// Notes: Instantiated in tb beside the first link.
`include "crs_cfg.svh"

module crs_link_sva (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic cold_reset_in_n,
    input wire logic system_reset_n,
    input wire logic [`CRS_DATA_W-1:0] memory_data_bus,
    input wire logic dev_data_oe,
    input wire logic ctl_data_oe,
    input wire logic xcvr_output_enable_n,
    input wire logic xcvr_direction_n,
    input wire logic system_clock_out,
    input wire logic dma_request_in_n,
    input wire logic dma_done_in_n
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic cold_q, fast_q, hold_q;
    logic [12:0] cnt;
    wire logic [12:0] next_cnt = !cold_reset_in_n ? 13'h0000 : !cold_q ? 13'h0001 :
        (cnt != 13'h0000 && !system_reset_n) ? cnt + 13'h0001 : 13'h0000;
    wire logic [12:0] reset_len = fast_q ? 13'h0042 : 13'h1002;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cold_q <= 1'b0;
            fast_q <= 1'b0;
            hold_q <= 1'b0;
            cnt <= 13'h0000;
        end else begin
            cold_q <= cold_reset_in_n;
            cnt <= next_cnt;
            if (!cold_reset_in_n) begin
                fast_q <= memory_data_bus[`CRS_VEC_FAST_RESET];
                hold_q <= memory_data_bus[`CRS_VEC_HOLD_CLOCK];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    property p_cold_enter;
        !cold_reset_in_n |=> !system_reset_n && !dev_data_oe && !xcvr_output_enable_n
            && !xcvr_direction_n;
    endproperty
    a_cold_enter: assert property (p_cold_enter) else $error("cold entry wrong");
    property p_vec_drive;
        !cold_reset_in_n |-> ctl_data_oe
            && memory_data_bus[`CRS_VEC_RSVD_HI:`CRS_VEC_RSVD_LO] == 2'h0;
    endproperty
    a_vec_drive: assert property (p_vec_drive) else $error("vector wrong");
    property p_release;
        $rose(cold_reset_in_n) |-> ctl_data_oe ##1 !ctl_data_oe;
    endproperty
    a_release: assert property (p_release) else $error("vector float order");
    property p_handover;
        $rose(cold_reset_in_n) |=> dev_data_oe && xcvr_output_enable_n && xcvr_direction_n;
    endproperty
    a_handover: assert property (p_handover) else $error("handover wrong");
    property p_reset_len;
        $rose(system_reset_n) && cnt != 13'h0000 |-> cnt == reset_len;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset length");
    property p_clk_run;
        !hold_q |=> $changed(system_clock_out);
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("clock not toggling");
    property p_clk_hold;
        hold_q && cold_reset_in_n && cold_q |=> $stable(system_clock_out);
    endproperty
    a_clk_hold: assert property (p_clk_hold) else $error("clock not held");
    property p_dma_req;
        $fell(dma_request_in_n) |=> !dma_request_in_n ##1 dma_request_in_n;
    endproperty
    a_dma_req: assert property (p_dma_req) else $error("request pulse");
    property p_dma_done;
        $fell(dma_done_in_n) |=> !dma_done_in_n ##1 dma_done_in_n;
    endproperty
    a_dma_done: assert property (p_dma_done) else $error("done pulse");
endmodule

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for both ends of the cold reset sequence.
// Assumes: One 40 MHz clock; NRST held 2 cycles.
// Notes: A second device on link_b is driven by hand.
`include "crs_cfg.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock, nrst, start, warm_reset, dma_request, dma_done, busy, sys_level;
    logic core_reset_n, warm_active, dma_req_active, dma_done_active, core_reset_n_b;
    logic [`CRS_VEC_W-1:0] boot_vector_in, boot_vector, boot_vector_b;
    int err_count, total_checks;

    crs_link_if link ();
    crs_link_if link_b ();

    crs_controller #(.COLD_HOLD_CYCLES(20)) i_crs_controller (.CLOCK(clock), .NRST(nrst),
        .START(start), .BOOT_VECTOR_IN(boot_vector_in), .WARM_RESET(warm_reset),
        .DMA_REQUEST(dma_request), .DMA_DONE(dma_done), .BUSY(busy),
        .SYSTEM_RESET_LEVEL(sys_level), .LINK(link.controller));
    crs_device i_crs_device (.CLOCK(clock), .NRST(nrst), .BOOT_VECTOR(boot_vector),
        .CORE_RESET_N(core_reset_n), .WARM_RESET_ACTIVE(warm_active),
        .DMA_REQUEST_ACTIVE(dma_req_active), .DMA_DONE_ACTIVE(dma_done_active),
        .LINK(link.device));
    crs_device i_crs_device_b (.CLOCK(clock), .NRST(nrst), .BOOT_VECTOR(boot_vector_b),
        .CORE_RESET_N(core_reset_n_b), .WARM_RESET_ACTIVE(), .DMA_REQUEST_ACTIVE(),
        .DMA_DONE_ACTIVE(), .LINK(link_b.device));
    crs_link_sva i_crs_link_sva (.CLOCK(clock), .NRST(nrst),
        .cold_reset_in_n(link.cold_reset_in_n), .system_reset_n(link.system_reset_n),
        .memory_data_bus(link.memory_data_bus), .dev_data_oe(link.dev_data_oe),
        .ctl_data_oe(link.ctl_data_oe), .xcvr_output_enable_n(link.xcvr_output_enable_n),
        .xcvr_direction_n(link.xcvr_direction_n), .system_clock_out(link.system_clock_out),
        .dma_request_in_n(link.dma_request_in_n), .dma_done_in_n(link.dma_done_in_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clock);
            #2;
        end
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_run(input logic [15:0] exp, input logic hold);
        logic c0;
        for (int i = 0; i < 4300 && core_reset_n !== 1'b1; i++)
            step(1);
        chk("core_reset_n", 1'b1, core_reset_n);
        chk16("boot_vector", exp, boot_vector);
        chk("xcvr_oe_n", 1'b1, link.xcvr_output_enable_n);
        chk("xcvr_dir_n", 1'b1, link.xcvr_direction_n);
        chk("dev_data_oe", 1'b1, link.dev_data_oe);
        c0 = link.system_clock_out;
        step(1);
        chk("sys_level", 1'b1, sys_level);
        chk("sysclk", hold ? c0 : !c0, link.system_clock_out);
    endtask

    task automatic t_cold(input logic [15:0] vec, input logic [15:0] exp, input logic hold);
        int n;
        boot_vector_in = vec;
        step(1);
        start = 1'b1;
        step(1);
        start = 1'b0;
        chk("busy", 1'b1, busy);
        step(3);
        chk("system_reset_n", 1'b0, link.system_reset_n);
        chk("dev_data_oe", 1'b0, link.dev_data_oe);
        chk("xcvr_oe_n", 1'b0, link.xcvr_output_enable_n);
        chk("xcvr_dir_n", 1'b0, link.xcvr_direction_n);
        chk("core_reset_n", 1'b0, core_reset_n);
        for (n = 3; n < 40 && link.cold_reset_in_n !== 1'b1; n++)
            step(1);
        chk("cold_hold", 1'b1, n >= 20);
        wait_run(exp, hold);
    endtask

    task automatic t_warm;
        warm_reset = 1'b1;
        for (int i = 0; i < 4 && link.system_reset_n !== 1'b0; i++)
            step(1);
        step(1);
        chk("warm_early", 1'b0, warm_active);
        for (int i = 0; i < 8 && (warm_active !== 1'b1 || core_reset_n !== 1'b0); i++)
            step(1);
        chk("warm_active", 1'b1, warm_active);
        chk("core_reset_n", 1'b0, core_reset_n);
        warm_reset = 1'b0;
        for (int i = 0; i < 8 && (warm_active !== 1'b0 || core_reset_n !== 1'b1); i++)
            step(1);
        chk("core_reset_n", 1'b1, core_reset_n);
    endtask

    task automatic t_dma;
        dma_request = 1'b1;
        dma_done = 1'b1;
        step(1);
        dma_request = 1'b0;
        dma_done = 1'b0;
        for (int i = 0; i < 3; i++) begin
            step(1);
            chk("dma_req", i < 2, dma_req_active);
            chk("dma_done", i < 2, dma_done_active);
        end
    endtask

    task automatic t_abort;
        int n;
        n = 0;
        link_b.ctl_data_out = 16'h0200;
        step(3);
        link_b.cold_reset_in_n = 1'b1;
        step(1);
        link_b.ctl_data_oe = 1'b0;
        step(8);
        chk("b_data_oe", 1'b1, link_b.dev_data_oe);
        chk("b_core_reset_n", 1'b0, core_reset_n_b);
        link_b.cold_reset_in_n = 1'b0;
        link_b.ctl_data_oe = 1'b1;
        link_b.ctl_data_out = 16'h0800;
        step(2);
        chk("b_data_oe", 1'b0, link_b.dev_data_oe);
        chk("b_system_reset_n", 1'b0, link_b.system_reset_n);
        link_b.cold_reset_in_n = 1'b1;
        step(1);
        link_b.ctl_data_oe = 1'b0;
        step(1);
        chk16("b_boot_vector", 16'h0800, boot_vector_b);
        for (n = 0; n < 4300 && core_reset_n_b !== 1'b1; n++)
            step(1);
        chk("b_core_reset_n", 1'b1, core_reset_n_b);
        chk("b_reset_long", 1'b1, n >= 4096);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        #500000;
        err_count++;
        finish_test();
    end

    initial begin
        err_count = 0;
        total_checks = 0;
        {nrst, start, warm_reset, dma_request, dma_done} = 5'h00;
        boot_vector_in = 16'h0000;
        link_b.cold_reset_in_n = 1'b0;
        link_b.ctl_data_out = 16'h0000;
        link_b.ctl_data_oe = 1'b1;
        link_b.ctl_system_reset_n_out = 1'b1;
        link_b.ctl_system_reset_oe = 1'b0;
        link_b.dma_request_in_n = 1'b1;
        link_b.dma_done_in_n = 1'b1;
        step(2);
        nrst = 1'b1;
        wait_run(16'h0000, 1'b0);
        t_cold(16'hCA5A, 16'h0A5A, 1'b1);
        t_cold(16'h0203, 16'h0203, 1'b0);
        t_warm();
        t_dma();
        t_abort();
        finish_test();
    end
endmodule
